// >>> bench/parallel_dsp_data_unit_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module parallel_dsp_data_unit_tb;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     issue_valid = 1'b0;
  pdu_pkg::pdu_instr_type   issue_instr = '0;
  logic [31:0]              issue_pc = 32'h0;
  logic [4:0]               reg_addr = 5'h0;
  logic [31:0]              reg_wdata = 32'h0;
  logic                     reg_we = 1'b0;
  logic                     reg_re = 1'b0;
  logic [31:0]              reg_rdata;
  pdu_pkg::pdu_mem_req_type mem_req0;
  pdu_pkg::pdu_mem_req_type mem_req1;
  logic [31:0]              mem_rdata0;
  logic [31:0]              mem_rdata1;
  logic                     redirect_valid;
  logic [31:0]              redirect_pc;
  int                       errors = 0;
  int                       tests_run = 0;
  int                       cycles = 0;
  logic [31:0]              seed = 32'h18;
  logic [31:0]              a, b, c, v;
  pdu_pkg::pdu_instr_type   i;

  always #10 clk = ~clk;

  pdu_data_unit dut (
    .clk(clk), .rst(rst), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .issue_pc(issue_pc), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .mem_req0(mem_req0), .mem_req1(mem_req1),
    .mem_rdata0(mem_rdata0), .mem_rdata1(mem_rdata1),
    .redirect_valid(redirect_valid), .redirect_pc(redirect_pc)
  );

  pdu_mem_model mem (
    .req0(mem_req0), .req1(mem_req1), .clk(clk),
    .rdata0(mem_rdata0), .rdata1(mem_rdata1)
  );

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] boolf(input logic [7:0] f,
                                        input logic [31:0] x, y, z);
    logic [31:0] r;
    for (int k = 0; k < 32; k++)
      r[k] = f[{x[k], y[k], z[k]}];
    return r;
  endfunction

  // carries stop at segment edges; w=32 makes the mask all ones
  function automatic logic [31:0] add_seg(input logic [31:0] x, y,
                                          input int w);
    logic [31:0] r;
    logic [31:0] m;
    r = 32'h0;
    m = (32'h1 << w) - 32'h1;
    for (int s = 0; s < 32; s += w)
      r = r | ((((x >> s) + (y >> s)) & m) << s);
    return r;
  endfunction

  function automatic pdu_pkg::pdu_instr_type mk(
      input pdu_pkg::pdu_op_type op, input logic [2:0] d, s1, s2, s3);
    pdu_pkg::pdu_instr_type r;
    r = '0;
    r.op = op;
    r.dst = d;
    r.s1 = s1;
    r.s2 = s2;
    r.s3 = s3;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // register bus and issue tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] ad, output logic [31:0] d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk_reg(input logic [4:0] ad, input logic [31:0] e);
    logic [31:0] d;
    rd(ad, d);
    `CHK(d, e)
    @(posedge clk);
    #1;
    `CHK(reg_rdata, 32'h0)
  endtask

  task automatic issue(input pdu_pkg::pdu_instr_type in,
                       input logic [31:0] pc);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_instr <= in;
    issue_pc <= pc;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
  endtask

  // write-back lands two edges after the take edge
  task automatic run(input pdu_pkg::pdu_instr_type in);
    issue(in, 32'h1000);
    repeat (3) @(posedge clk);
  endtask

  task automatic end_of_test();
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 21; k++)
      chk_reg(k[4:0], 32'h0);
    wr(5'h1f, rnd());
    chk_reg(5'h1f, 32'h0);
    for (int k = 1; k < 8; k++) begin
      v = rnd();
      wr(k[4:0], v);
      chk_reg(k[4:0], v);
    end
    for (int n = 0; n < 6; n++) begin
      a = rnd();
      b = rnd();
      c = rnd();
      wr(5'h1, a);
      wr(5'h2, b);
      wr(5'h3, c);
      issue(mk(pdu_pkg::OP_ADD, 3'h4, 3'h1, 3'h2, 3'h3), 32'h1000);
      issue(mk(pdu_pkg::OP_SUB, 3'h5, 3'h1, 3'h2, 3'h3), 32'h1008);
      repeat (3) @(posedge clk);
      chk_reg(5'h4, a + b);
      chk_reg(5'h5, a - b);
    end
    for (int f = 0; f < 256; f++) begin
      wr(5'h0, {5'h0, f[7:0], 19'h0});
      run(mk(pdu_pkg::OP_BOOL, 3'h6, 3'h1, 3'h2, 3'h3));
      chk_reg(5'h6, boolf(f[7:0], a, b, c));
    end
    wr(5'h0, 32'h0);
    wr(5'h5, 32'h0);
    wr(5'h7, c);
    i = mk(pdu_pkg::OP_ADD, 3'h7, 3'h1, 3'h2, 3'h3);
    i.cen = 1'b1;
    i.creg = 3'h5;
    run(i);
    chk_reg(5'h7, c);
    i.cinv = 1'b1;
    run(i);
    chk_reg(5'h7, a + b);
    i = mk(pdu_pkg::OP_ADD, 3'h7, 3'h1, 3'h2, 3'h3);
    i.sel = 1'b1;
    i.creg = 3'h5;
    run(i);
    chk_reg(5'h7, c + b);
    wr(5'h9, {30'h0, pdu_pkg::SPLIT_8});
    run(mk(pdu_pkg::OP_ADD, 3'h4, 3'h1, 3'h2, 3'h3));
    chk_reg(5'h4, add_seg(a, b, 8));
    wr(5'h9, {30'h0, pdu_pkg::SPLIT_16});
    run(mk(pdu_pkg::OP_ADD, 3'h4, 3'h1, 3'h2, 3'h3));
    chk_reg(5'h4, add_seg(a, b, 16));
    wr(5'h9, 32'h0);
    wr(5'h1, 32'h7fffffff);
    wr(5'h2, 32'h1);
    run(mk(pdu_pkg::OP_ADD, 3'h4, 3'h1, 3'h2, 3'h3));
    rd(5'h9, v);
    `CHK(v[pdu_pkg::SR_OVF:pdu_pkg::SR_STICKY], 2'h3)
    run(mk(pdu_pkg::OP_ADD, 3'h4, 3'h2, 3'h2, 3'h3));
    rd(5'h9, v);
    `CHK(v[pdu_pkg::SR_OVF:pdu_pkg::SR_STICKY], 2'h1)
    wr(5'h9, 32'h10);
    rd(5'h9, v);
    `CHK(v[pdu_pkg::SR_STICKY], 1'b0)
    wr(5'h1, 32'h0);
    run(mk(pdu_pkg::OP_LMO, 3'h4, 3'h1, 3'h1, 3'h1));
    chk_reg(5'h4, 32'h20);
    run(mk(pdu_pkg::OP_RMO, 3'h4, 3'h1, 3'h1, 3'h1));
    chk_reg(5'h4, 32'h20);
    wr(5'h1, 32'h1);
    run(mk(pdu_pkg::OP_RMO, 3'h4, 3'h1, 3'h1, 3'h1));
    chk_reg(5'h4, 32'h0);
    run(mk(pdu_pkg::OP_RMBC, 3'h4, 3'h1, 3'h1, 3'h1));
    chk_reg(5'h4, 32'h0);
    // both address units in one word: stores, then loads
    wr(5'h13, 32'h100);
    wr(5'h14, 32'h200);
    wr(5'h1, a);
    wr(5'h2, b);
    wr(5'h3, 32'h8);
    i = mk(pdu_pkg::OP_NOP, 3'h0, 3'h0, 3'h0, 3'h0);
    i.m1 = {4'b1110, 4'h0, 3'h1, 5'h04};
    i.m0 = {4'b1110, 4'h0, 3'h2, 5'h08};
    run(i);
    i.m1 = {4'b1010, 4'h0, 3'h6, 5'h04};
    i.m0 = {4'b1000, 4'h0, 3'h7, 5'h09};
    run(i);
    chk_reg(5'h6, a);
    chk_reg(5'h7, {24'h0, b[15:8]});
    i.m1 = '0;
    i.m0 = {4'b1010, 4'h2, 3'h6, 5'h02};
    run(i);
    chk_reg(5'h6, b);
    i.m0 = {4'b1010, 4'h1, 3'h7, 5'h03};
    run(i);
    chk_reg(5'h7, b);
    i.m0 = {4'b1010, 4'hc, 3'h5, 5'h08};
    run(i);
    chk_reg(5'h5, 32'h0);
    i = mk(pdu_pkg::OP_NOP, 3'h0, 3'h0, 3'h0, 3'h0);
    i.men = 1'b1;
    i.mdst = 3'h6;
    i.ms1 = 3'h1;
    i.ms2 = 3'h2;
    run(i);
    chk_reg(5'h6, {16'h0, a[15:0]} * {16'h0, b[15:0]});
    wr(5'h0, 32'h80);
    run(i);
    v[31:16] = {8'h0, a[15:8]} * {8'h0, b[15:8]};
    v[15:0] = {8'h0, a[7:0]} * {8'h0, b[7:0]};
    chk_reg(5'h6, v);
    wr(5'h0, 32'h4);
    run(mk(pdu_pkg::OP_ROT, 3'h4, 3'h1, 3'h1, 3'h1));
    chk_reg(5'h4, {a[27:0], a[31:28]});
    wr(5'h0, 32'h0);
    run(mk(pdu_pkg::OP_EXPAND, 3'h4, 3'h1, 3'h1, 3'h1));
    chk_reg(5'h4, {32{a[0]}});
    run(mk(pdu_pkg::OP_COMPRESS, 3'h4, 3'h1, 3'h1, 3'h1));
    chk_reg(5'h8, {31'h0, a[31]});
    wr(5'h0, 32'h9000);
    wr(5'h1, 32'h7fffffff);
    wr(5'h2, 32'h1);
    run(mk(pdu_pkg::OP_ADD, 3'h4, 3'h1, 3'h2, 3'h3));
    chk_reg(5'h4, pdu_pkg::SAT_MAX);
    wr(5'h0, 32'h0);
    wr(5'h0a, 32'h40);
    wr(5'h0d, 32'h80);
    wr(5'h10, 32'h2);
    for (int n = 0; n < 3; n++) begin
      issue(mk(pdu_pkg::OP_NOP, 3'h0, 3'h0, 3'h0, 3'h0), 32'h80);
      `CHK(redirect_valid, n < 2)
      if (n < 2)
        `CHK(redirect_pc, 32'h40)
      @(posedge clk);
      #1;
      `CHK(redirect_valid, 1'b0)
    end
    chk_reg(5'h10, 32'h0);
    end_of_test();
  end
endmodule

// >>> bench/pdu_mem_model.sv
`timescale 1ns/1ps
module pdu_mem_model (
  input  wire pdu_pkg::pdu_mem_req_type req0,
  input  wire pdu_pkg::pdu_mem_req_type req1,
  input  wire logic                     clk,
  output logic [31:0]                   rdata0,
  output logic [31:0]                   rdata1
);
  logic [31:0] mem [0:255];
  logic [31:0] last0 = 32'h0;
  logic [31:0] last1 = 32'h0;

  // ----------------------------------------------------------------
  // combinational read port per address unit
  // ----------------------------------------------------------------
  // an idle port shows the inverse of its last answer, so a load that
  // samples outside its valid cycle picks up wrong data
  assign rdata0 = (req0.valid && !req0.we) ? mem[req0.addr[9:2]] : ~last0;
  assign rdata1 = (req1.valid && !req1.we) ? mem[req1.addr[9:2]] : ~last1;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input pdu_pkg::pdu_mem_req_type r);
    logic [31:0] m;
    m = 32'hffffffff;
    if (r.size == pdu_pkg::SZ_BYTE)
      m = 32'hff << {r.addr[1:0], 3'h0};
    if (r.size == pdu_pkg::SZ_HALF)
      m = 32'hffff << {r.addr[1:0], 3'h0};
    return (old & ~m) | (r.wdata & m);
  endfunction

  always @(posedge clk) begin
    if (req0.valid && !req0.we)
      last0 <= rdata0;
    if (req1.valid && !req1.we)
      last1 <= rdata1;
    if (req0.valid && req0.we)
      mem[req0.addr[9:2]] <= merge(mem[req0.addr[9:2]], req0);
    if (req1.valid && req1.we)
      mem[req1.addr[9:2]] <= merge(mem[req1.addr[9:2]], req1);
  end
endmodule

// >>> verilog/pdu_data_unit.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module pdu_data_unit #(
  parameter int LOOPS = 3
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     issue_valid,
  input  wire pdu_pkg::pdu_instr_type   issue_instr,
  input  wire logic [31:0]              issue_pc,
  input  wire logic [4:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_we,
  input  wire logic                     reg_re,
  output logic      [31:0]              reg_rdata,
  output pdu_pkg::pdu_mem_req_type      mem_req0,
  output pdu_pkg::pdu_mem_req_type      mem_req1,
  input  wire logic [31:0]              mem_rdata0,
  input  wire logic [31:0]              mem_rdata1,
  output logic                          redirect_valid,
  output logic      [31:0]              redirect_pc
);
  // loop registers are mapped for three controllers only
  if (LOOPS < 1 || LOOPS > 3) begin : g_chk
    $error("LOOPS must be 1 to 3");
  end

  typedef struct packed {
    logic [7:0][31:0]               d;
    logic [31:0]                    mf;
    logic [31:0]                    sr;
    logic [2:0][31:0]               ls;
    logic [2:0][31:0]               le;
    logic [2:0][31:0]               lc;
    logic [1:0][31:0]               ab;
    logic                           p1_v;
    pdu_pkg::pdu_instr_type         p1;
    logic                           p2_av;
    logic [2:0]                     p2_ad;
    logic [31:0]                    p2_ar;
    logic                           p2_mv;
    logic [2:0]                     p2_md;
    logic [31:0]                    p2_mr;
    logic [1:0]                     p2_lv;
    logic [1:0][2:0]                p2_ld;
    logic [1:0][1:0]                p2_lsz;
    logic [1:0][1:0]                p2_lof;
    pdu_pkg::pdu_mem_req_type [1:0] mreq;
    logic [31:0]                    rdata;
    logic                           redir_v;
    logic [31:0]                    redir_pc;
  } pdu_state_type;

  pdu_state_type q;
  pdu_state_type n;
  logic          e_ovf;
  logic          e_sat;
  logic          e_cond;

  // position of highest set bit, 32 when none
  function automatic logic [31:0] left_one(input logic [31:0] x);
    logic [31:0] r;
    r = 32'h20;
    for (int k = 0; k < 32; k++) begin
      if (x[k]) r = 32'(k);
    end
    return r;
  endfunction

  function automatic logic [31:0] right_one(input logic [31:0] x);
    logic [31:0] r;
    r = 32'h20;
    for (int k = 31; k >= 0; k--) begin
      if (x[k]) r = 32'(k);
    end
    return r;
  endfunction

  function automatic logic [1:0] seg_of(input int i, input logic [1:0] sp);
    if (sp == pdu_pkg::SPLIT_8) return 2'(i);
    if (sp == pdu_pkg::SPLIT_16) return 2'(i / 2);
    return 2'h0;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    pdu_pkg::pdu_instr_type in;
    pdu_pkg::pdu_mslot_type sl;
    logic [31:0] d0, a, b, c, bb, boolr, sum, res, mask, off, ld, ea;
    logic [3:0]  co, sov;
    logic [1:0]  sp;
    logic        cy, cin, first, top, hit;
    n = q;
    in = q.p1;
    sl = '0;
    d0 = q.d[0];
    sp = q.sr[pdu_pkg::SR_SPLIT +: 2];
    a = '0; b = '0; c = '0; bb = '0; boolr = '0; sum = '0;
    res = '0; mask = '1; off = '0; ld = '0; ea = '0;
    co = '0; sov = '0; cy = 1'b0; cin = 1'b0;
    first = 1'b0; top = 1'b0; hit = 1'b0;
    e_ovf = 1'b0;
    e_sat = 1'b0;
    e_cond = 1'b1;
    n.rdata = '0;

    // ----------------------------------------------------------
    // register port
    // ----------------------------------------------------------
    if (reg_re) begin
      if (reg_addr < pdu_pkg::OFS_MF)
        n.rdata = q.d[reg_addr[2:0]];
      else if (reg_addr == pdu_pkg::OFS_MF)
        n.rdata = q.mf;
      else if (reg_addr == pdu_pkg::OFS_SR)
        n.rdata = q.sr;
      else if (reg_addr < pdu_pkg::OFS_LEND)
        n.rdata = q.ls[2'(reg_addr - pdu_pkg::OFS_LSTART)];
      else if (reg_addr < pdu_pkg::OFS_LCOUNT)
        n.rdata = q.le[2'(reg_addr - pdu_pkg::OFS_LEND)];
      else if (reg_addr < pdu_pkg::OFS_ABASE)
        n.rdata = q.lc[2'(reg_addr - pdu_pkg::OFS_LCOUNT)];
      else if (reg_addr < pdu_pkg::OFS_ABASE + 5'h2)
        n.rdata = q.ab[reg_addr[0] ^ pdu_pkg::OFS_ABASE[0]];
    end
    if (reg_we) begin
      if (reg_addr < pdu_pkg::OFS_MF)
        n.d[reg_addr[2:0]] = reg_wdata;
      else if (reg_addr == pdu_pkg::OFS_MF)
        n.mf = reg_wdata;
      else if (reg_addr == pdu_pkg::OFS_SR) begin
        // sticky bit is write-one-to-clear; the rest is plain
        n.sr = reg_wdata;
        n.sr[pdu_pkg::SR_STICKY] = q.sr[pdu_pkg::SR_STICKY]
          & ~reg_wdata[pdu_pkg::SR_STICKY];
      end
      else if (reg_addr < pdu_pkg::OFS_LEND)
        n.ls[2'(reg_addr - pdu_pkg::OFS_LSTART)] = reg_wdata;
      else if (reg_addr < pdu_pkg::OFS_LCOUNT)
        n.le[2'(reg_addr - pdu_pkg::OFS_LEND)] = reg_wdata;
      else if (reg_addr < pdu_pkg::OFS_ABASE)
        n.lc[2'(reg_addr - pdu_pkg::OFS_LCOUNT)] = reg_wdata;
      else if (reg_addr < pdu_pkg::OFS_ABASE + 5'h2)
        n.ab[reg_addr[0] ^ pdu_pkg::OFS_ABASE[0]] = reg_wdata;
    end

    // ----------------------------------------------------------
    // write-back stage: pipeline results win over software
    // ----------------------------------------------------------
    if (q.p2_av) n.d[q.p2_ad] = q.p2_ar;
    if (q.p2_mv) n.d[q.p2_md] = q.p2_mr;
    for (int u = 0; u < 2; u++) begin
      ld = (u == 0) ? mem_rdata0 : mem_rdata1;
      ld = ld >> {q.p2_lof[u], 3'b000};
      if (q.p2_lsz[u] == pdu_pkg::SZ_BYTE) ld = {24'h0, ld[7:0]};
      if (q.p2_lsz[u] == pdu_pkg::SZ_HALF) ld = {16'h0, ld[15:0]};
      if (q.p2_lv[u]) n.d[q.p2_ld[u]] = ld;
    end

    // ----------------------------------------------------------
    // loop controllers: innermost (lowest index) wins
    // ----------------------------------------------------------
    n.redir_v = 1'b0;
    for (int i = 0; i < LOOPS; i++) begin
      if (issue_valid && !hit && issue_pc == q.le[i] &&
          q.lc[i] != '0) begin
        hit = 1'b1;
        n.redir_v = 1'b1;
        n.redir_pc = q.ls[i];
        n.lc[i] = q.lc[i] - 32'h1;
      end
    end

    // ----------------------------------------------------------
    // execute stage
    // ----------------------------------------------------------
    e_cond = ((q.d[in.creg] != '0) ^ in.cinv);
    a = (in.sel && !e_cond) ? q.d[in.s3] : q.d[in.s1];
    b = q.d[in.s2];
    c = q.d[in.s3];
    for (int k = 0; k < 32; k++)
      boolr[k] = d0[pdu_pkg::D0_FUNC + {a[k], b[k], c[k]}];
    bb = d0[pdu_pkg::D0_ARITH] ? boolr : b;
    cin = d0[pdu_pkg::D0_CARRY];
    if (in.op == pdu_pkg::OP_SUB) begin
      bb = ~bb;
      cin = 1'b1;
    end
    // lane carries break at segment edges
    for (int i = 0; i < 4; i++) begin
      first = (i == 0) || (sp == pdu_pkg::SPLIT_8) ||
              (sp == pdu_pkg::SPLIT_16 && i == 2);
      top = (i == 3) || (sp == pdu_pkg::SPLIT_8) ||
            (sp == pdu_pkg::SPLIT_16 && i == 1);
      {cy, sum[i*8 +: 8]} = {1'b0, a[i*8 +: 8]} + {1'b0, bb[i*8 +: 8]}
                            + {8'h00, first ? cin : cy};
      if (top) begin
        co[seg_of(i, sp)] = cy;
        sov[seg_of(i, sp)] = (a[i*8+7] == bb[i*8+7]) &&
                             (sum[i*8+7] != a[i*8+7]);
      end
      mask[i*8 +: 8] = {8{q.mf[seg_of(i, sp)]}};
    end
    case (in.op)
      pdu_pkg::OP_BOOL:  res = boolr;
      pdu_pkg::OP_ADD,
      pdu_pkg::OP_SUB:   res = sum;
      pdu_pkg::OP_ROT:   res = (a << d0[pdu_pkg::D0_DBR +: 5]) |
                               (a >> (6'd32 - {1'b0,
                                d0[pdu_pkg::D0_DBR +: 5]}));
      pdu_pkg::OP_LMO:   res = left_one(a);
      pdu_pkg::OP_RMO:   res = right_one(a);
      pdu_pkg::OP_LMBC:  res = left_one({1'b0, a[30:0] ^ a[31:1]});
      pdu_pkg::OP_RMBC:  res = right_one({1'b0, a[30:0] ^ a[31:1]});
      pdu_pkg::OP_EXPAND: begin
        for (int i = 0; i < 4; i++)
          res[i*8 +: 8] = {8{a[seg_of(i, sp)]}};
      end
      default:           res = '0;
    endcase
    // saturation only makes sense for unsplit signed arithmetic
    if ((in.op == pdu_pkg::OP_ADD || in.op == pdu_pkg::OP_SUB) &&
        d0[pdu_pkg::D0_NMASK] && d0[pdu_pkg::D0_SAT] &&
        sp == 2'h0 && sov[0]) begin
      e_sat = q.p1_v;
      res = a[31] ? pdu_pkg::SAT_MIN : pdu_pkg::SAT_MAX;
    end
    if (d0[pdu_pkg::D0_EXPMF]) begin
      // mask keeps mf-derived lanes, the rest merges old dest
      res = (res & mask) | (q.d[in.dst] & ~mask);
    end else if (d0[pdu_pkg::D0_NMASK] && !d0[pdu_pkg::D0_SAT]) begin
      res = (res & c) | (q.d[in.dst] & ~c);
    end

    n.p2_av = q.p1_v && in.op != pdu_pkg::OP_NOP &&
              in.op != pdu_pkg::OP_COMPRESS &&
              (!in.cen || e_cond);
    n.p2_ad = in.dst;
    n.p2_ar = res;
    if (q.p1_v && (in.op == pdu_pkg::OP_ADD ||
                   in.op == pdu_pkg::OP_SUB)) begin
      e_ovf = |sov;
      n.mf = {28'h0, co};
      n.sr[pdu_pkg::SR_OVF] = |sov;
      n.sr[pdu_pkg::SR_CARRY] = |co;
      n.sr[pdu_pkg::SR_ZERO] = (sum == '0);
      n.sr[pdu_pkg::SR_NEG] = sum[31];
      if (|sov) n.sr[pdu_pkg::SR_STICKY] = 1'b1;
    end
    if (q.p1_v && in.op == pdu_pkg::OP_COMPRESS) begin
      n.mf = '0;
      for (int i = 0; i < 4; i++)
        n.mf[seg_of(i, sp)] = a[i*8+7];
    end

    // multiplier runs beside the ALU from the same word
    n.p2_mv = q.p1_v && in.men;
    n.p2_md = in.mdst;
    if (d0[pdu_pkg::D0_SPMPY])
      // each half is a full 16-bit product; an 8-bit self-sized
      // product inside the concatenation would lose its top byte
      n.p2_mr = {16'(q.d[in.ms1][15:8]) * 16'(q.d[in.ms2][15:8]),
                 16'(q.d[in.ms1][7:0]) * 16'(q.d[in.ms2][7:0])};
    else
      n.p2_mr = q.d[in.ms1][15:0] * q.d[in.ms2][15:0];
    n.p2_mr = n.p2_mr << d0[pdu_pkg::D0_DMS +: 2];

    // two address units
    for (int u = 0; u < 2; u++) begin
      sl = (u == 0) ? in.m0 : in.m1;
      off = sl.mode[0] ? q.d[sl.imm[2:0]] : {27'h0, sl.imm};
      if (sl.mode[1]) off = off << sl.size;
      ea = (sl.mode[3:2] == pdu_pkg::AM_POST) ? q.ab[u]
                                              : q.ab[u] + off;
      n.mreq[u].valid = q.p1_v && sl.en &&
                        sl.mode[3:2] != pdu_pkg::AM_BAD &&
                        sl.size != pdu_pkg::SZ_DBL;
      n.mreq[u].we = sl.we;
      n.mreq[u].size = sl.size;
      n.mreq[u].addr = ea;
      n.mreq[u].wdata = (sl.size == pdu_pkg::SZ_BYTE)
                        ? {4{q.d[sl.dreg][7:0]}}
                        : (sl.size == pdu_pkg::SZ_HALF)
                        ? {2{q.d[sl.dreg][15:0]}}
                        : q.d[sl.dreg];
      if (n.mreq[u].valid && sl.mode[3:2] != pdu_pkg::AM_OFFSET)
        n.ab[u] = q.ab[u] + off;
      n.p2_lv[u] = n.mreq[u].valid && !sl.we;
      n.p2_ld[u] = sl.dreg;
      n.p2_lsz[u] = sl.size;
      n.p2_lof[u] = ea[1:0];
    end

    // issue stage captures the 64-bit word
    n.p1_v = issue_valid;
    n.p1 = issue_instr;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata      = q.rdata;
  assign mem_req0       = q.mreq[0];
  assign mem_req1       = q.mreq[1];
  assign redirect_valid = q.redir_v;
  assign redirect_pc    = q.redir_pc;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_issue_alu;
    issue_valid && issue_instr.op != pdu_pkg::OP_NOP &&
    issue_instr.op != pdu_pkg::OP_COMPRESS && !issue_instr.cen;
  endsequence
  sequence s_exec_then_write;
    q.p1_v ##1 q.p2_av;
  endsequence

  a_pipe_depth: assert property (s_issue_alu |-> ##1 s_exec_then_write)
    else $error("alu result not written two cycles after issue");
  a_sticky_set: assert property (e_ovf |=> q.sr[pdu_pkg::SR_STICKY])
    else $error("overflow did not set sticky bit");
  a_sticky_hold: assert property (q.sr[pdu_pkg::SR_STICKY] &&
      !(reg_we && reg_addr == pdu_pkg::OFS_SR &&
        reg_wdata[pdu_pkg::SR_STICKY]) |=> q.sr[pdu_pkg::SR_STICKY])
    else $error("sticky overflow lost without clear");
  a_read_data: assert property (reg_re && reg_addr < pdu_pkg::OFS_MF
      |=> reg_rdata == $past(q.d[reg_addr[2:0]]))
    else $error("data register read mismatch");
  a_mem_issue: assert property (q.p1_v && q.p1.m0.en &&
      q.p1.m0.mode[3:2] != pdu_pkg::AM_BAD &&
      q.p1.m0.size != pdu_pkg::SZ_DBL |=> mem_req0.valid)
    else $error("memory access not issued");
  a_mode_refuse: assert property (q.p1_v &&
      q.p1.m1.mode[3:2] == pdu_pkg::AM_BAD |=> !mem_req1.valid)
    else $error("invalid address mode issued");
  a_cond_block: assert property (q.p1_v && q.p1.cen && !e_cond
      |=> !q.p2_av)
    else $error("conditional write not suppressed");
  a_sat_clamp: assert property (e_sat |=> q.p2_ar == pdu_pkg::SAT_MAX ||
      q.p2_ar == pdu_pkg::SAT_MIN)
    else $error("saturation did not clamp");
  a_loop_redirect: assert property (issue_valid && issue_pc == q.le[0] &&
      q.lc[0] != '0 |=> redirect_valid &&
      redirect_pc == $past(q.ls[0]))
    else $error("loop end did not redirect");
endmodule

// >>> verilog/pdu_pkg.sv
// Notes on behaviour
// - one instruction issues multiply, ALU, two memory accesses
// - three-input ALU does all 256 Boolean functions
// - input path merges data and expands bits
// - instruction word is 64 bits, several operations
// - three pipeline stages
// - multiplier does 16x16, optionally two 8x8
// - leftmost/rightmost one and bit change detection
// - segment flags translate to and from pixel bits
// - conditional write and conditional source selection
// - eight 32-bit data registers
// - first data register is extended ALU control
// - segment flags capture each split segment's status
// - segment flags expand into ALU mask
// - sticky overflow stays until software clears
// - two address units, two parallel 32-bit accesses
// - twelve addressing modes incl. scaled indexed
// - byte, halfword and word accesses
// - three zero-overhead loop controllers, nested, multi-end
// - every register is 32 bits wide
// - ALU splits as 1x32, 2x16 or 4x8
// - two control bits: normal, mask, saturate
package pdu_pkg;
  // ------------------------------------------------------------
  // register map (word index on the register port)
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_D0     = 5'h00;
  localparam logic [4:0] OFS_MF     = 5'h08;
  localparam logic [4:0] OFS_SR     = 5'h09;
  localparam logic [4:0] OFS_LSTART = 5'h0a;
  localparam logic [4:0] OFS_LEND   = 5'h0d;
  localparam logic [4:0] OFS_LCOUNT = 5'h10;
  localparam logic [4:0] OFS_ABASE  = 5'h13;
  localparam logic [31:0] REG_RESET = 32'h0;
  // ------------------------------------------------------------
  // control word and status fields
  // ------------------------------------------------------------
  localparam int D0_ARITH = 27;
  localparam int D0_FUNC  = 19;
  localparam int D0_CARRY = 18;
  localparam int D0_NMASK = 15;
  localparam int D0_EXPMF = 14;
  localparam int D0_SAT   = 12;
  localparam int D0_DMS   = 8;
  localparam int D0_SPMPY = 7;
  localparam int D0_DBR   = 0;
  localparam int SR_SPLIT  = 0;
  localparam int SR_STICKY = 4;
  localparam int SR_OVF    = 5;
  localparam int SR_CARRY  = 6;
  localparam int SR_ZERO   = 7;
  localparam int SR_NEG    = 8;
  localparam logic [1:0] SPLIT_16 = 2'h1;
  localparam logic [1:0] SPLIT_8  = 2'h2;
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_HALF  = 2'h1;
  localparam logic [1:0] SZ_DBL   = 2'h3;
  localparam logic [1:0] AM_OFFSET = 2'h0;
  localparam logic [1:0] AM_POST   = 2'h2;
  localparam logic [1:0] AM_BAD    = 2'h3;
  localparam logic [31:0] SAT_MAX = 32'h7fffffff;
  localparam logic [31:0] SAT_MIN = 32'h80000000;

  typedef enum logic [3:0] {
    OP_NOP, OP_BOOL, OP_ADD, OP_SUB, OP_ROT, OP_LMO, OP_RMO,
    OP_LMBC, OP_RMBC, OP_EXPAND, OP_COMPRESS
  } pdu_op_type;

  typedef struct packed {
    logic       en;
    logic       we;
    logic [1:0] size;
    logic [3:0] mode;
    logic [2:0] dreg;
    logic [4:0] imm;
  } pdu_mslot_type;

  typedef struct packed {
    pdu_op_type    op;
    logic [2:0]    dst;
    logic [2:0]    s1;
    logic [2:0]    s2;
    logic [2:0]    s3;
    logic          cen;
    logic          cinv;
    logic [2:0]    creg;
    logic          sel;
    logic          men;
    logic [2:0]    mdst;
    logic [2:0]    ms1;
    logic [2:0]    ms2;
    pdu_mslot_type m1;
    pdu_mslot_type m0;
  } pdu_instr_type;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pdu_mem_req_type;
endpackage
